// file: verilog/tfic_pkg.sv
// Constants shared by the thermal foldback and interrupt pin block.
package tfic_pkg;
    localparam logic [15:0] ADDR_IRQ_CTRL  = 16'h201F;
    localparam logic [15:0] ADDR_WARN1     = 16'h2020;
    localparam logic [15:0] ADDR_WARN2     = 16'h2021;
    localparam logic [15:0] ADDR_SHDN      = 16'h2022;
    localparam logic [15:0] ADDR_HYST      = 16'h2023;
    localparam logic [15:0] ADDR_FB_SET    = 16'h2024;
    localparam logic [15:0] ADDR_FB_EN     = 16'h2027;
    localparam logic [15:0] ADDR_FLAG_CLR2 = 16'h2016;

    localparam int IRQ_EN_BIT   = 0;
    localparam int INTERRUPT_PIN_POLARITY_BIT  = 1;
    localparam int IRQ_MODE_BIT = 2;
    localparam int FB_EN_BIT    = 0;
    localparam int WARN2_CLR_BIT = 7;
    localparam int SLOPE1_LSB   = 0;
    localparam int SLOPE2_LSB   = 2;
    localparam int RLS_LSB      = 4;
    localparam int HOLD_LSB     = 6;

    localparam logic [2:0] RST_IRQ_CTRL = 3'h0;
    localparam logic [6:0] RST_WARN1    = 7'h46;
    localparam logic [6:0] RST_WARN2    = 7'h52;
    localparam logic [6:0] RST_SHDN     = 7'h64;
    localparam logic [1:0] RST_HYST     = 2'h2;
    localparam logic [7:0] RST_FB_SET   = 8'hCA;
    localparam logic       RST_FB_EN    = 1'b1;

    // Highest usable code; larger codes read back unchanged but act as 150 C.
    localparam logic [7:0] TEMP_SAT_CODE = 8'h64;

    localparam int CLK_MHZ = 200;
    localparam int US_CYCLES = CLK_MHZ;
    localparam int ATTN_W = 11;
    localparam int TIME_W = 17;

    // Hold times in ms and release rates in ms per dB.
    localparam int HOLD_MS [4] = '{0, 20, 40, 80};
    localparam int RLS_MS_PER_DB [4] = '{3, 10, 100, 300};
    localparam int HYST_DEGC [4] = '{2, 5, 7, 10};

    // Attenuation counts quarter-dB steps, so one step is a quarter of a dB.
    localparam int STEPS_PER_DB = 4;

    typedef enum logic [1:0] {
        TFIC_IDLE    = 2'b00,
        TFIC_ACTIVE  = 2'b01,
        TFIC_HOLD    = 2'b11,
        TFIC_RELEASE = 2'b10
    } tfic_fb_state_t;
endpackage : tfic_pkg

// file: verilog/tfic_cfg_if.sv
// Foldback threshold and slope settings passed to the attenuation calculator.
`timescale 1ns/1ps
`default_nettype none
interface tfic_cfg_if;
    logic [6:0] warn1;
    logic [6:0] warn2;
    logic [1:0] slope1;
    logic [1:0] slope2;
    modport prov (output warn1, output warn2, output slope1, output slope2);
    modport use_m (input warn1, input warn2, input slope1, input slope2);
endinterface : tfic_cfg_if
`default_nettype wire

// file: verilog/tfic_attn.sv
// Piecewise foldback attenuation target for one temperature code.
`timescale 1ns/1ps
`default_nettype none
module tfic_attn (
    tfic_cfg_if.use_m                           cfg,
    input  wire logic [7:0]                     temp_i,
    output logic [tfic_pkg::ATTN_W-1:0]         target_o
);
    localparam int AW = tfic_pkg::ATTN_W;
    wire logic [7:0] t_sat;
    wire logic [7:0] w1_sat;
    wire logic [7:0] w2_sat;
    wire logic [7:0] w2_eff;
    wire logic [7:0] t_low;
    wire logic [7:0] d1;
    wire logic [7:0] d2;

    // Codes above the saturation point all mean 150 C.
    assign t_sat  = (temp_i > tfic_pkg::TEMP_SAT_CODE) ?
                    tfic_pkg::TEMP_SAT_CODE : temp_i;
    assign w1_sat = ({1'b0, cfg.warn1} > tfic_pkg::TEMP_SAT_CODE) ?
                    tfic_pkg::TEMP_SAT_CODE : {1'b0, cfg.warn1}; // [RULE_04]
    assign w2_sat = ({1'b0, cfg.warn2} > tfic_pkg::TEMP_SAT_CODE) ?
                    tfic_pkg::TEMP_SAT_CODE : {1'b0, cfg.warn2}; // [RULE_05]
    // A second limit below the first leaves no lower span.
    assign w2_eff = (w2_sat < w1_sat) ? w1_sat : w2_sat;
    assign t_low  = (t_sat < w2_eff) ? t_sat : w2_eff;
    assign d1 = (t_low > w1_sat) ? t_low - w1_sat : 8'h00; // [RULE_14]
    assign d2 = (t_sat > w2_eff) ? t_sat - w2_eff : 8'h00;
    // Slope code n gives 2^n quarter-dB per degree.
    assign target_o = (AW'(d1) << cfg.slope1) // [RULE_11]
                    + (AW'(d2) << cfg.slope2); // [RULE_10]
endmodule : tfic_attn
`default_nettype wire

// file: verilog/tfic_top.sv
// Thermal foldback control, threshold registers and interrupt pin driver.
// What this block does
// [RULE_01] Drive-select bit: open-drain or push-pull pin.
// [RULE_02] Pin asserts on any flag, polarity selectable.
// [RULE_03] Enable cleared keeps interrupt pin undriven.
// [RULE_04] First warning limit code, saturating at 150 C.
// [RULE_05] Second warning limit, reset codes 0x52, 0x46.
// [RULE_06] Shutdown limit code, reset 0x64.
// [RULE_07] Hysteresis 2, 5, 7, 10 C, reset code 2.
// [RULE_08] Release waits for cooled hold time.
// [RULE_09] Release rate 3, 10, 100, 300 ms/dB.
// [RULE_10] Slope above second limit selectable, reset 1 dB.
// [RULE_11] Slope between limits selectable, reset 1 dB.
// [RULE_12] Foldback enable bit, set after reset.
// [RULE_13] Clear bit zeroes second-warning state and flag.
// [RULE_14] Attenuation zero below first limit, piecewise slopes.
`timescale 1ns/1ps
`default_nettype none
module tfic_top #(
    parameter int US_CYCLES = tfic_pkg::US_CYCLES,
    parameter int N_FLAGS   = 8
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic [15:0]                reg_addr_i,
    input  wire logic [7:0]                 reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic [7:0]                      reg_rdata_o,
    input  wire logic [6:0]                 temp_code_i,
    input  wire logic [N_FLAGS-1:0]         ext_flags_i,
    output logic [tfic_pkg::ATTN_W-1:0]     attn_o,
    output logic                            shutdown_o,
    output logic                            warn2_begin_state_o,
    output logic                            warn2_begin_flag_o,
    output logic                            irq_o,
    output logic                            irq_oe_o
);
    localparam int AW = tfic_pkg::ATTN_W;
    localparam int TW = tfic_pkg::TIME_W;

    if (US_CYCLES < 1 || US_CYCLES > 65535 || N_FLAGS < 1) begin : g_bad_param
        $error("tfic_top: unsupported parameter values");
    end

    logic [2:0] irq_ctrl;
    logic [6:0] warn1;
    logic [6:0] warn2;
    logic [6:0] shdn;
    logic [1:0] hyst;
    logic [7:0] fb_set;
    logic       fb_en;
    logic       warn2_active;
    tfic_pkg::tfic_fb_state_t state;
    tfic_pkg::tfic_fb_state_t next_state;
    logic [AW-1:0] next_attn;
    logic [TW-1:0] tm_cnt;
    logic [TW-1:0] next_tm_cnt;
    logic [15:0]   us_cnt;

    // Register decode.
    wire logic wr_irq   = reg_wr_i && reg_addr_i == tfic_pkg::ADDR_IRQ_CTRL;
    wire logic wr_warn1 = reg_wr_i && reg_addr_i == tfic_pkg::ADDR_WARN1;
    wire logic wr_warn2 = reg_wr_i && reg_addr_i == tfic_pkg::ADDR_WARN2;
    wire logic wr_shdn  = reg_wr_i && reg_addr_i == tfic_pkg::ADDR_SHDN;
    wire logic wr_hyst  = reg_wr_i && reg_addr_i == tfic_pkg::ADDR_HYST;
    wire logic wr_fbset = reg_wr_i && reg_addr_i == tfic_pkg::ADDR_FB_SET;
    wire logic wr_fben  = reg_wr_i && reg_addr_i == tfic_pkg::ADDR_FB_EN;
    wire logic wr_clr2  = reg_wr_i && reg_addr_i == tfic_pkg::ADDR_FLAG_CLR2;
    wire logic warn2_clr = wr_clr2 &&
                           reg_wdata_i[tfic_pkg::WARN2_CLR_BIT]; // [RULE_13]

    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr_i)
            tfic_pkg::ADDR_IRQ_CTRL: rd_mux = {5'h00, irq_ctrl};
            tfic_pkg::ADDR_WARN1:    rd_mux = {1'b0, warn1};
            tfic_pkg::ADDR_WARN2:    rd_mux = {1'b0, warn2};
            tfic_pkg::ADDR_SHDN:     rd_mux = {1'b0, shdn};
            tfic_pkg::ADDR_HYST:     rd_mux = {6'h00, hyst};
            tfic_pkg::ADDR_FB_SET:   rd_mux = fb_set;
            tfic_pkg::ADDR_FB_EN:    rd_mux = {7'h00, fb_en};
            default:                 rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_ctrl <= tfic_pkg::RST_IRQ_CTRL;
            warn1    <= tfic_pkg::RST_WARN1; // [RULE_05]
            warn2    <= tfic_pkg::RST_WARN2; // [RULE_05]
            shdn     <= tfic_pkg::RST_SHDN; // [RULE_06]
            hyst     <= tfic_pkg::RST_HYST; // [RULE_07]
            fb_set   <= tfic_pkg::RST_FB_SET; // [RULE_10]
            fb_en    <= tfic_pkg::RST_FB_EN; // [RULE_12]
            reg_rdata_o <= 8'h00;
        end else begin
            if (wr_irq)   irq_ctrl <= reg_wdata_i[2:0];
            if (wr_warn1) warn1 <= reg_wdata_i[6:0]; // [RULE_04]
            if (wr_warn2) warn2 <= reg_wdata_i[6:0];
            if (wr_shdn)  shdn <= reg_wdata_i[6:0];
            if (wr_hyst)  hyst <= reg_wdata_i[1:0];
            if (wr_fbset) fb_set <= reg_wdata_i;
            if (wr_fben)  fb_en <= reg_wdata_i[tfic_pkg::FB_EN_BIT];
            if (reg_rd_i) reg_rdata_o <= rd_mux;
        end
    end

    // Threshold comparisons with hysteresis.
    wire logic [1:0] hold_sel = fb_set[tfic_pkg::HOLD_LSB +: 2];
    wire logic [1:0] rls_sel  = fb_set[tfic_pkg::RLS_LSB +: 2];
    wire logic [7:0] hyst_deg = 8'(tfic_pkg::HYST_DEGC[hyst]); // [RULE_07]
    wire logic [7:0] temp8    = {1'b0, temp_code_i};
    wire logic [7:0] temp_hot = temp8 + hyst_deg;
    wire logic [7:0] shdn_sat = ({1'b0, shdn} > tfic_pkg::TEMP_SAT_CODE) ?
                                tfic_pkg::TEMP_SAT_CODE : {1'b0, shdn};
    wire logic [7:0] w2_sat   = ({1'b0, warn2} > tfic_pkg::TEMP_SAT_CODE) ?
                                tfic_pkg::TEMP_SAT_CODE : {1'b0, warn2};
    wire logic shdn_set = temp8 >= shdn_sat; // [RULE_06]
    wire logic shdn_rel = temp_hot < shdn_sat; // [RULE_07]
    wire logic warn2_set = temp8 >= w2_sat;
    wire logic warn2_rel = temp_hot < w2_sat; // [RULE_07]
    wire logic warn2_rise = warn2_set && !warn2_active;

    tfic_cfg_if cfg_bus ();
    assign cfg_bus.warn1  = warn1;
    assign cfg_bus.warn2  = warn2;
    assign cfg_bus.slope1 = fb_set[tfic_pkg::SLOPE1_LSB +: 2];
    assign cfg_bus.slope2 = fb_set[tfic_pkg::SLOPE2_LSB +: 2];

    wire logic [AW-1:0] target;
    wire logic [AW-1:0] target_cool;
    tfic_attn u_attn_now (
        .cfg      (cfg_bus.use_m),
        .temp_i   (temp8),
        .target_o (target)
    );
    // Target as if the die were hysteresis degrees hotter: when even this
    // lies below the applied attenuation, the die has cooled enough.
    tfic_attn u_attn_cool (
        .cfg      (cfg_bus.use_m),
        .temp_i   (temp_hot),
        .target_o (target_cool)
    );

    // Microsecond tick for hold and release timing.
    wire logic us_tick = us_cnt == 16'(US_CYCLES - 1);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            us_cnt <= 16'h0000;
        end else begin
            us_cnt <= us_tick ? 16'h0000 : us_cnt + 16'h0001;
        end
    end

    wire logic [TW-1:0] hold_us = TW'(tfic_pkg::HOLD_MS[hold_sel] * 1000);
    wire logic [TW-1:0] step_us = TW'(tfic_pkg::RLS_MS_PER_DB[rls_sel] * 1000
                                      / tfic_pkg::STEPS_PER_DB);
    wire logic heat  = target > attn_o;
    wire logic cool  = target_cool < attn_o;
    wire logic [TW-1:0] tm_inc = us_tick ? tm_cnt + TW'(1) : tm_cnt;

    always_comb begin
        next_state  = state;
        next_attn   = attn_o;
        next_tm_cnt = tm_inc;
        case (state)
            tfic_pkg::TFIC_IDLE: begin
                next_attn = '0; // [RULE_14]
                next_tm_cnt = '0;
                if (target != '0) begin
                    next_state = tfic_pkg::TFIC_ACTIVE;
                    next_attn  = target;
                end
            end
            tfic_pkg::TFIC_ACTIVE: begin
                next_tm_cnt = '0;
                if (heat) begin
                    next_attn = target;
                end else if (cool) begin
                    next_state = tfic_pkg::TFIC_HOLD;
                end
            end
            tfic_pkg::TFIC_HOLD: begin
                if (heat || !cool) begin
                    next_state  = tfic_pkg::TFIC_ACTIVE;
                    next_attn   = heat ? target : attn_o;
                    next_tm_cnt = '0;
                end else if (tm_cnt >= hold_us) begin // [RULE_08]
                    next_state  = tfic_pkg::TFIC_RELEASE;
                    next_tm_cnt = '0;
                end
            end
            tfic_pkg::TFIC_RELEASE: begin
                if (heat || !cool) begin
                    next_state  = tfic_pkg::TFIC_ACTIVE;
                    next_attn   = heat ? target : attn_o;
                    next_tm_cnt = '0;
                end else if (attn_o == '0) begin
                    next_state = tfic_pkg::TFIC_IDLE;
                end else if (tm_inc >= step_us) begin // [RULE_09]
                    next_attn   = attn_o - AW'(1);
                    next_tm_cnt = '0;
                end
            end
            default: begin
                next_state = tfic_pkg::TFIC_IDLE;
                next_attn  = '0;
                next_tm_cnt = '0;
            end
        endcase
        if (!fb_en) begin // [RULE_12]
            next_state  = tfic_pkg::TFIC_IDLE;
            next_attn   = '0;
            next_tm_cnt = '0;
        end
    end

    // Second-warning begin event: a new set wins over a clear.
    wire logic next_w2_state = warn2_rise ||
                               (warn2_begin_state_o && !warn2_clr); // [RULE_13]
    wire logic next_w2_flag  = warn2_rise ||
                               (warn2_begin_flag_o && !warn2_clr); // [RULE_13]
    wire logic any_flag = warn2_begin_flag_o || (|ext_flags_i); // [RULE_02]
    wire logic pin_lvl  = irq_ctrl[tfic_pkg::INTERRUPT_PIN_POLARITY_BIT] ? any_flag
                                                          : !any_flag;
    wire logic next_oe  = irq_ctrl[tfic_pkg::IRQ_EN_BIT] && // [RULE_03]
                          (irq_ctrl[tfic_pkg::IRQ_MODE_BIT] || !pin_lvl); // [RULE_01]

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state  <= tfic_pkg::TFIC_IDLE;
            attn_o <= '0;
            tm_cnt <= '0;
            shutdown_o   <= 1'b0;
            warn2_active <= 1'b0;
            warn2_begin_state_o <= 1'b0;
            warn2_begin_flag_o  <= 1'b0;
            irq_o    <= 1'b0;
            irq_oe_o <= 1'b0;
        end else begin
            state  <= next_state;
            attn_o <= next_attn;
            tm_cnt <= next_tm_cnt;
            if (shdn_set) shutdown_o <= 1'b1;
            else if (shdn_rel) shutdown_o <= 1'b0;
            if (warn2_set) warn2_active <= 1'b1;
            else if (warn2_rel) warn2_active <= 1'b0;
            warn2_begin_state_o <= next_w2_state;
            warn2_begin_flag_o  <= next_w2_flag;
            irq_o    <= pin_lvl; // [RULE_02]
            irq_oe_o <= next_oe;
        end
    end
endmodule : tfic_top
`default_nettype wire

// file: verilog/tfic_attn_dummy_never.sv
// Holds no logic of its own; the block lives in the other design files.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: tb/tfic_host.sv
// Host side of the interrupt pin with its board pull-up.
`timescale 1ns/1ps
`default_nettype none
module tfic_host (
    input  wire logic irq_i,
    input  wire logic irq_oe_i,
    output logic      pin_o
);
    // An undriven pin settles high through the pull-up.
    assign pin_o = irq_oe_i ? irq_i : 1'b1;
endmodule : tfic_host
`default_nettype wire

// file: tb/tfic_top_monitor.sv
// Port checker of the thermal foldback and interrupt pin block.
`timescale 1ns/1ps
`default_nettype none
module tfic_top_monitor #(
    parameter int N_FLAGS = 8
) (
    input wire logic                        clk_i,
    input wire logic                        rst_n_i,
    input wire logic [15:0]                 reg_addr_i,
    input wire logic [7:0]                  reg_wdata_i,
    input wire logic                        reg_wr_i,
    input wire logic [6:0]                  temp_code_i,
    input wire logic [N_FLAGS-1:0]          ext_flags_i,
    input wire logic [tfic_pkg::ATTN_W-1:0] attn_o,
    input wire logic                        shutdown_o,
    input wire logic                        warn2_begin_state_o,
    input wire logic                        warn2_begin_flag_o,
    input wire logic                        irq_o,
    input wire logic                        irq_oe_o
);
    logic [2:0] ctl;
    logic       fen;
    logic [6:0] w1;
    logic [6:0] w2;
    logic [6:0] sd;
    wire        any = warn2_begin_flag_o | (|ext_flags_i);
    wire        clr = reg_wr_i && reg_wdata_i[7]
                      && reg_addr_i == tfic_pkg::ADDR_FLAG_CLR2;
    // Shadow copies of the settings, updated by register writes.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctl <= 3'h0;
            fen <= 1'b1;
            w1  <= 7'h46;
            w2  <= 7'h52;
            sd  <= 7'h64;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                tfic_pkg::ADDR_IRQ_CTRL: ctl <= reg_wdata_i[2:0];
                tfic_pkg::ADDR_WARN1:    w1 <= reg_wdata_i[6:0];
                tfic_pkg::ADDR_WARN2:    w2 <= reg_wdata_i[6:0];
                tfic_pkg::ADDR_SHDN:     sd <= reg_wdata_i[6:0];
                tfic_pkg::ADDR_FB_EN:    fen <= reg_wdata_i[0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Codes above the saturation point all act as 150 C.
    wire logic [6:0] w2_lim = (w2 > 7'h64) ? 7'h64 : w2;
    sequence s_clr;
        clr && temp_code_i < w2_lim;
    endsequence
    a_pin_hiz: assert property (!ctl[0] |=> !irq_oe_o)
        else $error("interrupt pin driven while disabled");
    a_pin_level: assert property (ctl[0] |=>
        irq_o == ($past(ctl[1]) ? $past(any) : !$past(any)))
        else $error("interrupt pin level wrong");
    a_open_drain: assert property (ctl[0] && !ctl[2] |=>
        irq_oe_o == !irq_o)
        else $error("open-drain pin drives high");
    a_push_pull: assert property (ctl[0] && ctl[2] |=> irq_oe_o)
        else $error("push-pull pin not driven");
    a_fold_off: assert property (!fen |=> attn_o == '0)
        else $error("attenuation while foldback off");
    a_attn_zero: assert property (attn_o == '0 &&
        temp_code_i <= w1 |=> attn_o == '0)
        else $error("attenuation below first limit");
    a_shdn_set: assert property (temp_code_i >= sd |=> shutdown_o)
        else $error("shutdown missing above limit");
    a_state_sticky: assert property (warn2_begin_state_o && !clr
        |=> warn2_begin_state_o)
        else $error("begin state lost without clear");
    a_clear_both: assert property (s_clr |=>
        !warn2_begin_state_o && !warn2_begin_flag_o)
        else $error("clear left state or flag set");
endmodule : tfic_top_monitor
bind tfic_top tfic_top_monitor #(.N_FLAGS(N_FLAGS)) u_mon (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .temp_code_i(temp_code_i), .ext_flags_i(ext_flags_i),
    .attn_o(attn_o), .shutdown_o(shutdown_o),
    .warn2_begin_state_o(warn2_begin_state_o),
    .warn2_begin_flag_o(warn2_begin_flag_o),
    .irq_o(irq_o), .irq_oe_o(irq_oe_o)
);
`default_nettype wire

// file: tb/thermal_foldback_irq_control_test.sv
// Self-checking bench of the thermal foldback and interrupt pin block.
`timescale 1ns/1ps
`default_nettype none
module thermal_foldback_irq_control_test;
    logic                        clk = 1'b0;
    logic                        rst_n = 1'b0;
    logic [15:0]                 addr = 16'h0000;
    logic [7:0]                  wdata = 8'h00;
    logic                        wr = 1'b0;
    logic                        rd = 1'b0;
    logic [6:0]                  temp = 7'h00;
    logic [7:0]                  flags = 8'h00;
    logic [7:0]                  rdata;
    logic [tfic_pkg::ATTN_W-1:0] attn;
    logic                        shdn, st, fl, irq, oe, pin;
    int                          n_fail = 0;
    int                          check_count = 0;
    always #2.5 clk = ~clk;
    tfic_top #(.US_CYCLES(1)) DUT (
        .clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .temp_code_i(temp), .ext_flags_i(flags),
        .attn_o(attn), .shutdown_o(shdn), .warn2_begin_state_o(st),
        .warn2_begin_flag_o(fl), .irq_o(irq), .irq_oe_o(oe)
    );
    tfic_host HOST (.irq_i(irq), .irq_oe_i(oe), .pin_o(pin));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, e);
    endtask : rd_chk
    task automatic t_reset;
        logic [15:0] ad [9] = '{16'h201F, 16'h2020, 16'h2021, 16'h2022,
            16'h2023, 16'h2024, 16'h2027, 16'h2025, 16'h2016};
        logic [7:0]  ex [9] = '{8'h00, 8'h46, 8'h52, 8'h64, 8'h02,
            8'hCA, 8'h01, 8'h00, 8'h00};
        for (int i = 0; i < 4; i++) begin
            rd_chk(ad[i], ex[i]);
        end
        for (int i = 4; i < 9; i++) begin
            rd_chk(ad[i], ex[i]);
        end
    endtask : t_reset
    task automatic t_irq;
        logic lv;
        for (int c = 0; c < 16; c++) begin
            wr_reg(16'h201F, {5'h00, c[2:0]});
            flags = c[3] ? 8'h80 : 8'h00;
            cyc(2);
            lv = c[1] ? c[3] : !c[3];
            chk(oe, c[0] & (c[2] | !lv));
            chk(pin, c[0] ? lv : 1'b1);
        end
        flags = 8'h00;
    endtask : t_irq
    task automatic t_rw;
        wr_reg(16'h2023, 8'hFF);
        rd_chk(16'h2023, 8'h03);
        wr_reg(16'h2023, 8'h02);
        wr_reg(16'h2020, 8'h64);
        temp = 7'h7F;
        cyc(3);
        chk(attn, 11'h000);
        chk(shdn, 1'b1);
        temp = 7'h5D;
        cyc(3);
        chk(shdn, 1'b1);
        temp = 7'h5C;
        cyc(3);
        chk(shdn, 1'b0);
        temp = 7'h00;
        cyc(3);
    endtask : t_rw
    task automatic t_fold;
        logic [7:0] tab [8] = '{8'h00, 8'h04, 8'h01, 8'h05, 8'h06,
            8'h0D, 8'h0B, 8'h0F};
        logic [tfic_pkg::ATTN_W-1:0] ex_at;
        wr_reg(16'h2024, 8'h00);
        wr_reg(16'h2020, 8'h10);
        wr_reg(16'h2021, 8'h14);
        temp = 7'h10;
        cyc(2);
        chk(attn, 11'h000);
        temp = 7'h16;
        for (int i = 0; i < 8; i++) begin
            wr_reg(16'h2024, tab[i]);
            cyc(2);
            ex_at = (11'h004 << tab[i][1:0]) + (11'h002 << tab[i][3:2]);
            chk(attn, ex_at);
        end
        wr_reg(16'h2027, 8'h00);
        cyc(1);
        chk(attn, 11'h000);
        wr_reg(16'h2027, 8'h01);
        cyc(2);
        chk(attn, 11'h030);
    endtask : t_fold
    task automatic t_rel;
        int k;
        wr_reg(16'h2024, 8'h4F);
        temp = 7'h00;
        cyc(19900);
        chk(attn, 11'h030);
        for (k = 0; k < 1500; k++) begin
            @(negedge clk);
            if (attn !== 11'h030) break;
        end
        if (k == 1500) begin
            n_fail++;
            report_and_stop;
        end else begin
            chk(attn, 11'h02F);
            chk(k >= 840 && k <= 860, 1'b1);
        end
    endtask : t_rel
    task automatic t_clr;
        wr_reg(16'h201F, 8'h07);
        cyc(2);
        chk(pin, 1'b1);
        wr_reg(16'h2016, 8'h7F);
        cyc(1);
        chk({st, fl}, 2'h3);
        wr_reg(16'h2016, 8'h80);
        cyc(1);
        chk({st, fl}, 2'h0);
        cyc(1);
        chk(pin, 1'b0);
    endtask : t_clr
    initial begin
        cyc(10);
        rst_n = 1'b1;
        t_reset;
        t_irq;
        t_rw;
        t_fold;
        t_rel;
        t_clr;
        report_and_stop;
    end
endmodule : thermal_foldback_irq_control_test
`default_nettype wire
